// >>> design/ccg_clock_reset.sv
// Decided for this implementation: the APB slave port.
`timescale 1ns/10ps
module ccg_clock_reset #(
	parameter int RST_DELAY_TICKS = ccg_pkg::RST_DELAY_TICKS
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic main_osc_in,
	input wire logic guard_opt,
	input wire logic reset_pin_n,
	input wire logic por_req,
	input wire logic wdg_timeout,
	input wire logic lvd_low,
	input wire logic stop_mode,
	output logic main_osc_en,
	output logic aux_osc_run,
	output logic clk_src_aux,
	output logic fint_tick,
	output logic timer_tick,
	output logic core_tick,
	output logic core_reset,
	output logic io_pullup
);
	ccg_pkg::ccg_rst_state_type state_q;
	ccg_pkg::ccg_rst_state_type state_d;
	logic [7:0] conv_q;
	logic [7:0] clkctl_q;
	logic guard_en_q;
	logic [8:0] aux_cnt_q;
	logic aux_run_q;
	logic aux_tick_q;
	logic aux_wrap;
	logic aux_allow;
	logic main_edge;
	logic main_ok;
	logic src_tick;
	logic any_src;
	logic in_reset;
	logic [11:0] dly_q;
	logic dly_last;
	logic setup;
	logic access;
	logic hit;
	logic [7:0] rd_byte;
	logic [7:0] status;
	logic main_osc_en_q;
	logic clk_src_aux_q;
	logic core_reset_q;
	logic io_pullup_q;
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;

	////////////////////////////////////////////////////////////////
	// Main oscillator edge guard and divider
	ccg_edge_guard u_guard (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.osc_in(main_osc_in),
		.guard_en(guard_en_q),
		.edge_ok_q(main_edge),
		.main_ok_q(main_ok)
	);

	// Ticks switch source in the cycle main_ok changes, even inside an auxiliary period
	assign src_tick = main_ok ? main_edge : aux_tick_q;

	ccg_divider u_div (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.clr(in_reset),
		.tick_in(src_tick),
		.sel({clkctl_q[ccg_pkg::DIV_HI_BIT], clkctl_q[ccg_pkg::DIV_LO_BIT]}),
		.fint_q(fint_tick),
		.timer_tick_q(timer_tick),
		.core_tick_q(core_tick)
	);

	////////////////////////////////////////////////////////////////
	// Guard option, caught only while held in reset
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			guard_en_q <= 1'b0;
		end else if (state_q == ccg_pkg::RS_HOLD) begin
			guard_en_q <= guard_opt;
		end
	end

	////////////////////////////////////////////////////////////////
	// Auxiliary slow oscillator
	// Stop mode parks it too, unless reset wants a clock for its delay
	assign aux_allow = guard_en_q & ~(stop_mode & ~in_reset);
	assign aux_wrap = (aux_cnt_q == 9'(ccg_pkg::SLOW_CYC - 1));

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			aux_cnt_q <= 9'h000;
			aux_run_q <= 1'b0;
			aux_tick_q <= 1'b0;
		end else if (!aux_allow || main_ok) begin
			aux_cnt_q <= 9'h000;
			aux_run_q <= 1'b0;
			aux_tick_q <= 1'b0;
		end else begin
			aux_cnt_q <= aux_wrap ? 9'h000 : aux_cnt_q + 9'h001;
			// First period after the miss only arms the oscillator
			if (aux_wrap) begin
				aux_run_q <= 1'b1;
			end
			aux_tick_q <= aux_wrap & aux_run_q;
		end
	end

	////////////////////////////////////////////////////////////////
	// Reset sequencer
	// No mode gating: the pin acts in run, wait and stop alike
	assign any_src = ~reset_pin_n | por_req | wdg_timeout | lvd_low;
	assign in_reset = (state_q != ccg_pkg::RS_RUN);
	assign dly_last = (dly_q == 12'(RST_DELAY_TICKS - 1));

	always_comb begin
		state_d = state_q;
		case (state_q)
			ccg_pkg::RS_HOLD: begin
				// Delay counts only once some oscillator runs
				if (!any_src && (main_ok || aux_run_q)) begin
					state_d = ccg_pkg::RS_DELAY;
				end
			end
			ccg_pkg::RS_DELAY: begin
				if (any_src) begin
					state_d = ccg_pkg::RS_HOLD;
				end else if (src_tick && dly_last) begin
					state_d = ccg_pkg::RS_RUN;
				end
			end
			ccg_pkg::RS_RUN: begin
				if (any_src) begin
					state_d = ccg_pkg::RS_HOLD;
				end
			end
			default: state_d = ccg_pkg::RS_HOLD;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ccg_pkg::RS_HOLD;
		end else begin
			state_q <= state_d;
		end
	end

	// Delay counted in source ticks, so a slow clock stretches it
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			dly_q <= 12'h000;
		end else if (state_q != ccg_pkg::RS_DELAY) begin
			dly_q <= 12'h000;
		end else if (src_tick && !dly_last) begin
			dly_q <= dly_q + 12'h001;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			core_reset_q <= 1'b1;
			io_pullup_q <= 1'b1;
		end else begin
			core_reset_q <= (state_d != ccg_pkg::RS_RUN);
			io_pullup_q <= (state_d != ccg_pkg::RS_RUN);
		end
	end

	////////////////////////////////////////////////////////////////
	// Oscillator control
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			main_osc_en_q <= 1'b1;
			clk_src_aux_q <= 1'b0;
		end else begin
			if (in_reset) begin
				main_osc_en_q <= 1'b1;
			end else begin
				main_osc_en_q <= ~stop_mode & ~(guard_en_q & conv_q[ccg_pkg::OSC_OFF_BIT]);
			end
			clk_src_aux_q <= ~main_ok & aux_run_q;
		end
	end

	////////////////////////////////////////////////////////////////
	// APB slave, one wait-free access phase
	assign setup = psel & ~penable;
	assign access = psel & penable & pready_q;
	assign hit = (paddr == ccg_pkg::ADDR_CONV) || (paddr == ccg_pkg::ADDR_CLK) ||
		(paddr == ccg_pkg::ADDR_STAT);

	always_comb begin
		status = 8'h00;
		status[ccg_pkg::ST_MAIN_OK] = main_ok;
		status[ccg_pkg::ST_AUX_RUN] = aux_run_q;
		status[ccg_pkg::ST_SRC_AUX] = clk_src_aux_q;
		status[ccg_pkg::ST_GUARD] = guard_en_q;
		status[ccg_pkg::ST_RESET] = core_reset_q;
		case (paddr)
			ccg_pkg::ADDR_CONV: rd_byte = conv_q;
			ccg_pkg::ADDR_STAT: rd_byte = status;
			default: rd_byte = 8'h00;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h00000000;
		end else begin
			pready_q <= setup;
			pslverr_q <= setup & ~hit;
			if (setup) begin
				prdata_q <= pwrite ? 32'h00000000 : {24'h000000, rd_byte};
			end
		end
	end

	// Internal reset puts both registers back to their reset values
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			conv_q <= ccg_pkg::CONV_RESET;
			clkctl_q <= ccg_pkg::CLK_RESET;
		end else if (in_reset) begin
			conv_q <= ccg_pkg::CONV_RESET;
			clkctl_q <= ccg_pkg::CLK_RESET;
		end else if (access && pwrite) begin
			if (paddr == ccg_pkg::ADDR_CONV) begin
				conv_q <= pwdata[7:0];
			end
			// Only the select bits are kept; the rest must be written zero
			if (paddr == ccg_pkg::ADDR_CLK) begin
				clkctl_q <= pwdata[7:0] & ccg_pkg::CLK_WMASK;
			end
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign main_osc_en = main_osc_en_q;
	assign aux_osc_run = aux_run_q;
	assign clk_src_aux = clk_src_aux_q;
	assign core_reset = core_reset_q;
	assign io_pullup = io_pullup_q;

	////////////////////////////////////////////////////////////////
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	a_aux_needs_option: assert property (!guard_en_q |=> !aux_run_q)
		else $error("auxiliary oscillator ran without guard option");
	a_aux_off_main: assert property (main_ok |=> !aux_run_q && !aux_tick_q)
		else $error("auxiliary oscillator kept running with main");
	a_aux_start_late: assert property (guard_en_q && !main_ok && !aux_run_q && !stop_mode
		|=> !aux_tick_q)
		else $error("auxiliary ticked inside its first period");
	a_osc_off_bit: assert property (!in_reset && !stop_mode && guard_en_q &&
		conv_q[ccg_pkg::OSC_OFF_BIT] |=> !main_osc_en_q)
		else $error("disable bit did not stop main oscillator");
	a_off_needs_guard: assert property (!in_reset && !stop_mode && !guard_en_q |=> main_osc_en_q)
		else $error("main oscillator stopped without guard option");
	a_reset_restarts: assert property (in_reset |=> ##1 main_osc_en_q && !conv_q[ccg_pkg::OSC_OFF_BIT])
		else $error("reset did not restart main oscillator");
	a_reset_on_source: assert property (any_src |=> core_reset_q && io_pullup_q)
		else $error("reset source not honoured");
	a_pin_pulse_stretch: assert property ($fell(reset_pin_n) |=> core_reset_q [*8])
		else $error("short pin pulse not stretched");
	a_release_on_delay: assert property (state_q == ccg_pkg::RS_DELAY && !any_src && src_tick &&
		dly_last |=> !core_reset_q)
		else $error("release missed end of delay");
	a_clkreg_write_only: assert property (setup && !pwrite && paddr == ccg_pkg::ADDR_CLK
		|=> prdata == 32'h00000000 && pready)
		else $error("clock control register read back");

	c_aux_takes_over: cover property (guard_en_q && $fell(main_ok) ##[1:1000] aux_run_q);
	c_reset_release: cover property ($fell(core_reset_q));
	c_div_write: cover property (access && pwrite && paddr == ccg_pkg::ADDR_CLK && pwdata[1]);
endmodule : ccg_clock_reset

// >>> inc/ccg_pkg.sv
package ccg_pkg;
	// Register indices; byte address is four times the index
	localparam logic [9:0] IDX_CONV = 10'h0D1;
	localparam logic [9:0] IDX_CLK = 10'h0DC;
	localparam logic [9:0] IDX_STAT = 10'h0E0;
	localparam logic [11:0] ADDR_CONV = {IDX_CONV, 2'b00};
	localparam logic [11:0] ADDR_CLK = {IDX_CLK, 2'b00};
	localparam logic [11:0] ADDR_STAT = {IDX_STAT, 2'b00};
	localparam logic [7:0] CONV_RESET = 8'h40;
	localparam logic [7:0] CLK_RESET = 8'h00;
	localparam logic [7:0] CLK_WMASK = 8'h03;
	localparam int OSC_OFF_BIT = 2;
	localparam int DIV_LO_BIT = 0;
	localparam int DIV_HI_BIT = 1;
	localparam int ST_MAIN_OK = 0;
	localparam int ST_AUX_RUN = 1;
	localparam int ST_SRC_AUX = 2;
	localparam int ST_GUARD = 3;
	localparam int ST_RESET = 4;
	// Timing
	localparam int CLK_PERIOD_NS = 5;
	localparam int SLOW_PERIOD_NS = 2000;
	localparam int SLOW_CYC = SLOW_PERIOD_NS / CLK_PERIOD_NS;
	localparam int GUARD_MIN_NS = 100;
	localparam int GUARD_CYC = (GUARD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int MISS_NS = 500;
	localparam int MISS_CYC = MISS_NS / CLK_PERIOD_NS;
	localparam int RST_DELAY_TICKS = 2048;
	localparam int TIMER_DIV = 12;
	localparam int CORE_DIV = 13;
	localparam logic [1:0] SEL_DIV1 = 2'b00;
	localparam logic [1:0] SEL_DIV2 = 2'b01;
	localparam logic [1:0] RATIO1 = 2'h0;
	localparam logic [1:0] RATIO2 = 2'h1;
	localparam logic [1:0] RATIO4 = 2'h3;
	typedef enum logic [2:0] {
		RS_HOLD = 3'h1,
		RS_DELAY = 3'h2,
		RS_RUN = 3'h4
	} ccg_rst_state_type;
endpackage : ccg_pkg

// >>> design/ccg_edge_guard.sv
`timescale 1ns/10ps
module ccg_edge_guard (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic osc_in,
	input wire logic guard_en,
	output logic edge_ok_q,
	output logic main_ok_q
);
	logic osc_prev_q;
	logic [7:0] gap_q;
	logic rise;
	logic accept;

	assign rise = osc_in & ~osc_prev_q;
	// Edges closer than the guard limit are spikes or over-frequency
	// Gap reads one less than the edge spacing, so an edge exactly at the limit passes
	assign accept = rise & (~guard_en | (gap_q >= 8'(ccg_pkg::GUARD_CYC - 1)));

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			osc_prev_q <= 1'b0;
			gap_q <= 8'h00;
			edge_ok_q <= 1'b0;
			main_ok_q <= 1'b0;
		end else begin
			osc_prev_q <= osc_in;
			edge_ok_q <= accept;
			if (accept) begin
				gap_q <= 8'h00;
			end else if (gap_q != 8'hFF) begin
				gap_q <= gap_q + 8'h01;
			end
			// Running flag drops once no edge has been accepted for more than MISS_CYC cycles
			if (accept) begin
				main_ok_q <= 1'b1;
			end else if (gap_q >= 8'(ccg_pkg::MISS_CYC)) begin
				main_ok_q <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	a_guard_drops_spike: assert property (edge_ok_q && guard_en |=> !edge_ok_q [*8])
		else $error("guarded edges closer than limit");
endmodule : ccg_edge_guard

// >>> design/ccg_divider.sv
`timescale 1ns/10ps
module ccg_divider (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic clr,
	input wire logic tick_in,
	input wire logic [1:0] sel,
	output logic fint_q,
	output logic timer_tick_q,
	output logic core_tick_q
);
	logic [1:0] cnt_q;
	logic [1:0] last;
	logic [1:0] ticks_q;

	always_comb begin
		case (sel)
			ccg_pkg::SEL_DIV1: last = ccg_pkg::RATIO1;
			ccg_pkg::SEL_DIV2: last = ccg_pkg::RATIO2;
			default: last = ccg_pkg::RATIO4;
		endcase
	end

	// Compare with >= so a ratio cut mid-count ends the phase at once
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 2'h0;
			fint_q <= 1'b0;
		end else if (clr) begin
			cnt_q <= 2'h0;
			fint_q <= 1'b0;
		end else begin
			fint_q <= tick_in && (cnt_q >= last);
			if (tick_in) begin
				cnt_q <= (cnt_q >= last) ? 2'h0 : cnt_q + 2'h1;
			end
		end
	end

	localparam int DIVS [2] = '{ccg_pkg::TIMER_DIV, ccg_pkg::CORE_DIV};
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_div
			logic [3:0] c_q;
			always_ff @(posedge clk_sys or negedge rst_n) begin
				if (!rst_n) begin
					c_q <= 4'h0;
					ticks_q[gi] <= 1'b0;
				end else begin
					ticks_q[gi] <= fint_q && (c_q == 4'(DIVS[gi] - 1));
					if (fint_q) begin
						c_q <= (c_q == 4'(DIVS[gi] - 1)) ? 4'h0 : c_q + 4'h1;
					end
				end
			end
		end
	endgenerate
	assign timer_tick_q = ticks_q[0];
	assign core_tick_q = ticks_q[1];

	////////////////////////////////////////////////////////////////
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	a_div_by_one: assert property (sel == 2'b00 && tick_in && !clr |=> fint_q)
		else $error("ratio one missed a tick");
	a_div_no_two: assert property (fint_q && sel[1] && !clr |=> !fint_q [*3])
		else $error("ratio four produced close ticks");
endmodule : ccg_divider

// >>> dv/ccg_xtal_model.sv
`timescale 1ns/10ps
module ccg_xtal_model #(
	parameter int HALF = 20
) (
	input wire logic clk_sys,
	input wire logic osc_en,
	input wire logic broken,
	input wire logic fast,
	input wire logic pin_low,
	output logic main_osc_in,
	output logic reset_pin_n
);
	int cnt_q = 0;
	logic osc_q = 1'b0;
	////////////////////////////////////////////////////////////////
	// Resonator stands still while disabled or defective
	always_ff @(posedge clk_sys) begin
		if (!osc_en || broken) begin
			cnt_q <= 0;
		end else if (cnt_q >= (fast ? 1 : HALF - 1)) begin
			cnt_q <= 0;
			osc_q <= !osc_q;
		end else begin
			cnt_q <= cnt_q + 1;
		end
	end
	assign main_osc_in = osc_q;
	// Board pull-up keeps the pin high unless pulled low
	assign reset_pin_n = !pin_low;
endmodule : ccg_xtal_model

// >>> dv/test_clock_guard_and_reset_control.sv
`timescale 1ns/10ps
module test_clock_guard_and_reset_control;
	localparam int DLY = 4;
	localparam int HALF = 20;
	logic clk_sys, rst_n, psel, penable, pwrite, guard_opt, pin_low, fast, broken;
	logic por_req, wdg_timeout, lvd_low, stop_mode, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic pready, pslverr, main_osc_in, reset_pin_n, main_osc_en, aux_osc_run, clk_src_aux;
	logic fint_tick, timer_tick, core_tick, core_reset, io_pullup;
	logic [7:0] clk_img;
	int mismatches, n_tests, n;
	////////////////////////////////////////////////////////////////
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	ccg_clock_reset #(.RST_DELAY_TICKS(DLY)) DUT (.clk_sys, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .main_osc_in, .guard_opt, .reset_pin_n, .por_req, .wdg_timeout, .lvd_low,
		.stop_mode, .main_osc_en, .aux_osc_run, .clk_src_aux, .fint_tick, .timer_tick, .core_tick, .core_reset,
		.io_pullup);
	ccg_xtal_model #(.HALF(HALF)) xtal (.clk_sys, .osc_en(main_osc_en), .broken, .fast, .pin_low,
		.main_osc_in, .reset_pin_n);
	////////////////////////////////////////////////////////////////
	task cmp(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	task cmp_bit(input logic got, input logic exp);
		cmp({31'h0, got}, {31'h0, exp});
	endtask : cmp_bit
	// Idle cycle first, so psel is never assigned twice in one step
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk_sys);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (pready !== 1'b1) mismatches++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task rdc(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		cmp(rd, exp);
	endtask : rdc
	function automatic logic sel(input int s);
		case (s)
			0: return core_reset;
			1: return aux_osc_run;
			3: return fint_tick;
			4: return timer_tick;
			default: return core_tick;
		endcase
	endfunction : sel
	task wait_for(input int s, input logic v, input int lim, output int c);
		c = 0;
		while (sel(s) !== v && c < lim) begin
			@(posedge clk_sys);
			c++;
		end
	endtask : wait_for
	// Cycles between two pulses of the selected tick
	task per(input int s, output int c);
		wait_for(s, 1'b1, 3000, c);
		@(posedge clk_sys);
		wait_for(s, 1'b1, 3000, c);
		c++;
	endtask : per
	task finish_test;
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : finish_test
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (60000) @(posedge clk_sys);
		mismatches++;
		finish_test();
	end
	initial begin
		{rst_n, psel, penable, pwrite, pin_low, fast, broken, wdg_timeout, lvd_low, stop_mode} = '0;
		{guard_opt, por_req} = 2'b11;
		paddr = 12'h000;
		pwdata = 32'h0;
		clk_img = 8'h00;
		mismatches = 0;
		n_tests = 0;
		repeat (8) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (100) @(posedge clk_sys);
		cmp_bit(core_reset & io_pullup, 1'b1);
		por_req <= 1'b0;
		wait_for(0, 1'b0, 2000, n);
		cmp_bit(n >= (DLY - 1) * 2 * HALF && n <= (DLY + 1) * 2 * HALF, 1'b1);
		rdc(ccg_pkg::ADDR_CONV, {24'h0, ccg_pkg::CONV_RESET});
		apb(1'b0, 12'h004, 32'h0);
		cmp_bit(err, 1'b1);
		$display("power-up test done");
		for (int s = 0; s < 4; s++) begin
			clk_img = 8'(s);
			apb(1'b1, ccg_pkg::ADDR_CLK, {24'h0, clk_img});
			per(3, n);
			cmp(n, (s == 0) ? 2 * HALF : (s == 1) ? 4 * HALF : 8 * HALF);
		end
		rdc(ccg_pkg::ADDR_CLK, 32'h0);
		clk_img = 8'h00;
		apb(1'b1, ccg_pkg::ADDR_CLK, 32'h0);
		per(4, n);
		cmp(n, 12 * 2 * HALF);
		per(5, n);
		cmp(n, 13 * 2 * HALF);
		fast <= 1'b1;
		per(3, n);
		per(3, n);
		cmp(n, ccg_pkg::GUARD_CYC);
		fast <= 1'b0;
		$display("divider test done");
		apb(1'b1, ccg_pkg::ADDR_CONV, 32'h44);
		repeat (2) @(posedge clk_sys);
		cmp_bit(main_osc_en, 1'b0);
		wait_for(1, 1'b1, 1000, n);
		cmp_bit(n >= ccg_pkg::SLOW_CYC && n <= ccg_pkg::SLOW_CYC + ccg_pkg::MISS_CYC + 10, 1'b1);
		// Source flag follows the run flag one clock later
		@(posedge clk_sys);
		cmp_bit(clk_src_aux, 1'b1);
		per(3, n);
		cmp(n, ccg_pkg::SLOW_CYC);
		rdc(ccg_pkg::ADDR_STAT, 32'h0E);
		apb(1'b1, ccg_pkg::ADDR_CONV, 32'h40);
		wait_for(1, 1'b0, 200, n);
		cmp_bit(n <= 2 * HALF + 5, 1'b1);
		$display("auxiliary test done");
		for (int s = 0; s < 4; s++) begin
			apb(1'b1, ccg_pkg::ADDR_CONV, 32'h44);
			{pin_low, por_req, wdg_timeout, lvd_low} <= 4'h8 >> s;
			@(posedge clk_sys);
			{pin_low, por_req, wdg_timeout, lvd_low} <= 4'h0;
			wait_for(0, 1'b1, 5, n);
			cmp_bit(core_reset & io_pullup, 1'b1);
			repeat (2) @(posedge clk_sys);
			cmp_bit(main_osc_en, 1'b1);
			wait_for(0, 1'b0, 2000, n);
			cmp_bit(n >= (DLY - 1) * 2 * HALF, 1'b1);
			rdc(ccg_pkg::ADDR_CONV, {24'h0, ccg_pkg::CONV_RESET});
		end
		stop_mode <= 1'b1;
		repeat (2) @(posedge clk_sys);
		cmp_bit(main_osc_en, 1'b0);
		pin_low <= 1'b1;
		guard_opt <= 1'b0;
		repeat (300) @(posedge clk_sys);
		cmp(32'({core_reset, io_pullup, main_osc_en}), 32'h7);
		{stop_mode, pin_low} <= 2'b00;
		wait_for(0, 1'b0, 2000, n);
		cmp_bit(core_reset, 1'b0);
		apb(1'b1, ccg_pkg::ADDR_CONV, 32'h44);
		broken <= 1'b1;
		repeat (700) @(posedge clk_sys);
		cmp(32'({main_osc_en, aux_osc_run}), 32'h2);
		$display("reset test done");
		finish_test();
	end
endmodule : test_clock_guard_and_reset_control
